/* bench/ext_mem_partner.sv */
`timescale 1ns/1ps
// =====
// memories on the far side of the pins
module ext_mem_partner (
  input wire i_core_clk, // clock
  input wire [2:0] i_wait, // wait cycles
  input wire i_fault, // answer with exception
  input wire [27:0] i_addr, // address pins
  input wire [31:0] i_data_out, // device drive
  input wire [31:0] i_data_oe_n, // device enable
  input wire i_oe_n, // read enable
  input wire i_write_n, // write strobe
  input wire [3:0] i_bws_n, // lane strobes
  input wire [7:0] i_sel_n, // all selects
  output wire [31:0] o_bus, // bus level
  output logic o_ready_n, // ready pin
  output logic o_exc_n // exception pin
);
  logic [31:0] mem [logic [33:0]];
  logic [31:0] drv = 32'h5a5a_a5a5;
  logic [31:0] w;
  int cnt = 0;
  wire [33:0] key = {i_sel_n, i_addr[27:2]};
  // released lines toggle so a stale value can never pass for data
  assign o_bus = (i_data_out & ~i_data_oe_n) | (drv & i_data_oe_n);
  // wait states, answer and storage of the selected device
  always @(posedge i_core_clk) begin
    drv <= (!i_oe_n && mem.exists(key)) ? mem[key] : ~drv;
    if (&i_sel_n) begin
      cnt <= 0;
      o_ready_n <= 1'b1;
      o_exc_n <= 1'b1;
    end else begin
      cnt <= cnt + 1;
      o_ready_n <= cnt < i_wait;
      o_exc_n <= cnt < i_wait || !i_fault;
      if (!i_write_n) begin
        w = mem.exists(key) ? mem[key] : 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
          if (!i_bws_n[i]) w[31-8*i -: 8] = o_bus[31-8*i -: 8];
        end
        mem[key] = w;
      end
    end
  end
endmodule

/* bench/ext_mem_pins_checker.sv */
`timescale 1ns/1ps
// =====
// pin protocol checks
module ext_mem_pins_checker (
  input wire i_core_clk, // clock
  input wire i_arst_n, // reset
  input wire i_psel, // apb select
  input wire i_penable, // apb access
  input wire i_bus_ready_n, // ready pin
  input wire o_pready, // apb ready
  input wire o_ack, // done pulse
  input wire o_oe_n, // read oe
  input wire o_read, // read strobe
  input wire o_write_n, // write strobe
  input wire o_cb_oe_n, // cb enable
  input wire [31:0] o_data_oe_n, // data enable
  input wire [3:0] o_byte_write_strobe_n, // lanes
  input wire [1:0] o_boot_rom_select_n, // rom
  input wire [4:0] o_static_ram_bank_select_n, // ram
  input wire [4:0] o_static_ram_bank_output_enable_n, // ram oe
  input wire o_io_area_select_n // io
);
  default clocking ck @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  // low gpio lines are excluded: in gpio mode they drive outside stores
  wire [7:0] sel = ~{o_boot_rom_select_n, o_static_ram_bank_select_n, o_io_area_select_n};
  one_select_a: assert property ($onehot0(sel)) else $error("two selects");
  ram_pair_a: assert property ((~o_static_ram_bank_output_enable_n &
    o_static_ram_bank_select_n) == 5'h00) else $error("ram oe without select");
  read_pair_a: assert property (o_read == !o_oe_n) else $error("read strobes differ");
  cb_write_a: assert property (o_cb_oe_n == o_write_n) else $error("cb drive");
  store_drive_a: assert property (!(&o_data_oe_n[31:16]) |-> !o_write_n)
    else $error("data driven outside store");
  lane_write_a: assert property (!(&o_byte_write_strobe_n) |-> !o_write_n && o_oe_n)
    else $error("lane strobe outside write");
  ready_end_a: assert property ($rose(o_ack) && $past(o_read || !o_write_n)
    |-> $past(!i_bus_ready_n, 3)) else $error("ack without ready");
  strobe_end_a: assert property (o_ack |-> o_write_n && o_oe_n && o_read == 1'b0)
    else $error("strobe past ack");
  apb_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("apb answer late");
  cover property (!o_write_n ##[1:20] o_ack);
  cover property (o_read ##[1:20] o_ack);
  cover property (o_pready);
endmodule
bind ext_mem_pins ext_mem_pins_checker chk_i (.i_core_clk, .i_arst_n, .i_psel, .i_penable,
  .i_bus_ready_n, .o_pready, .o_ack, .o_oe_n, .o_read, .o_write_n, .o_cb_oe_n, .o_data_oe_n,
  .o_byte_write_strobe_n, .o_boot_rom_select_n, .o_static_ram_bank_select_n,
  .o_static_ram_bank_output_enable_n, .o_io_area_select_n);

/* bench/ext_mem_pins_tb.sv */
`timescale 1ns/1ps
`include "ext_mem_map.vh"
module ext_mem_pins_tb;
  logic i_core_clk = '0, i_arst_n = '0, i_psel = '0, i_penable = '0, i_pwrite = '0;
  logic i_req = '0, i_cached = '0, i_write = '0, i_fault = '0, pe, tcb7 = '0;
  logic [7:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, i_addr = '0, i_wdata = '0, o_prdata, o_rdata;
  logic [1:0] i_size = '0;
  logic [2:0] i_wait = '0;
  logic o_pready, o_pslverr, o_irq, o_ack, o_err, o_cb_oe_n, o_oe_n, o_read, o_write_n;
  logic o_io_area_select_n;
  wire i_bus_ready_n, i_bus_exception_n;
  wire [31:0] i_data_in;
  logic [27:0] o_addr;
  logic [31:0] o_data_out, o_data_oe_n;
  logic [7:0] o_cb_out;
  logic [3:0] o_byte_write_strobe_n;
  logic [1:0] o_boot_rom_select_n;
  logic [4:0] o_static_ram_bank_select_n, o_static_ram_bank_output_enable_n;
  int n_fail = 0, n_tests = 0, cyc = 0, first_sel = 0;
  logic [31:0] ref_mem [logic [31:0]];
  logic [31:0] areas [11] = '{32'h0000_0000, 32'h1000_0000, 32'h2000_0000, 32'h3000_0000,
    32'h4000_0000, 32'h4100_0000, 32'h4200_0000, 32'h4300_0000, 32'h4400_0000,
    32'h4500_0000, 32'h8000_0000};
  wire [7:0] sel = ~{o_boot_rom_select_n, o_static_ram_bank_select_n, o_io_area_select_n};
  ext_mem_pins dut (.i_core_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_irq, .i_req, .i_cached, .i_write,
    .i_size, .i_addr, .i_wdata, .o_ack, .o_err, .o_rdata, .o_addr, .i_data_in, .o_data_out,
    .o_data_oe_n, .o_cb_out, .o_cb_oe_n, .o_oe_n, .o_read, .o_write_n,
    .o_byte_write_strobe_n, .o_boot_rom_select_n, .o_static_ram_bank_select_n,
    .o_static_ram_bank_output_enable_n, .o_io_area_select_n, .i_bus_ready_n,
    .i_bus_exception_n);
  ext_mem_partner mem (.i_core_clk, .i_wait, .i_fault, .i_addr(o_addr), .i_data_out(o_data_out),
    .i_data_oe_n(o_data_oe_n), .i_oe_n(o_oe_n), .i_write_n(o_write_n),
    .i_bws_n(o_byte_write_strobe_n), .i_sel_n(~sel), .o_bus(i_data_in),
    .o_ready_n(i_bus_ready_n), .o_exc_n(i_bus_exception_n));
  // =====
  // clock and hang guard
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    // cycle of the first select seen, to time the restart after reset
    if (sel != 8'h00 && first_sel == 0) first_sel <= cyc;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test;
    end
  end
  // =====
  // helpers
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // select one-hot {rom1, rom0, ram4..ram0, io}; unmapped gives none
  function automatic logic [7:0] xsel(input logic [31:0] a);
    if (a[30]) return (a[26:24] < 3'h5) ? 8'h02 << a[26:24] : 8'h00;
    if (a[31]) return 8'h00;
    return a[29] ? 8'h01 : (a[28] ? 8'h80 : 8'h40);
  endfunction
  // outputs read right after an edge still hold that edge's sampled values
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_core_clk);
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    r = o_prdata;
    pe = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask
  task acc(input logic w, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] xb, output logic [31:0] rd, output logic er);
    logic seen;
    @(posedge i_core_clk);
    {i_req, i_write, i_size, i_addr, i_wdata} <= {1'b1, w, sz, a, d};
    i_wait <= 3'($urandom % 4);
    seen = 1'b0;
    do begin
      @(posedge i_core_clk);
      if (sel != 8'h00 && !seen) begin
        seen = 1'b1;
        chk(sel, xsel(a));
        chk(o_addr, a[27:0]);
        chk({o_write_n, o_oe_n, o_read, o_byte_write_strobe_n}, {!w, w, !w, xb});
        chk({~o_static_ram_bank_output_enable_n}, w ? 8'h00 : (xsel(a) >> 1) & 8'h1f);
        if (w) chk(o_cb_out[7], tcb7);
        if (w && sz == 2'h2) chk(o_data_oe_n, 32'h0);
        if (w && xb == 4'he) chk(o_data_out[31:24], d[31-8*a[1:0] -: 8]);
      end
    end while (o_ack !== 1'b1);
    chk(seen, xsel(a) != 8'h00);
    rd = o_rdata;
    er = o_err;
    i_req <= 1'b0;
  endtask
  // =====
  // main sequence
  initial begin
    logic [31:0] r, v, a, a0;
    logic [3:0] m;
    logic e;
    int t;
    void'($urandom(32'h2b43));
    repeat (16) @(posedge i_core_clk);
    chk({sel, &{o_data_oe_n, o_cb_oe_n, o_write_n, o_oe_n, ~o_read}}, 9'h001);
    i_arst_n <= 1'b1;
    t = cyc;
    acc(1'b1, 2'h2, 32'h4000_0000, 32'h1234_5678, 4'h0, r, e);
    chk(cyc - t > 10, 1'b1);
    chk(first_sel - t > 6, 1'b1);
    apb(1'b0, `REG_CFG, 32'h0, r);
    chk(r, `CFG_RESET);
    apb(1'b0, 8'h20, 32'h0, r);
    chk(pe, 1'b1);
    foreach (areas[i]) begin
      a = areas[i] | 32'(($urandom % 64) << 2);
      v = $urandom;
      acc(1'b1, 2'h2, a, v, (xsel(a) != 8'h00) ? 4'h0 : 4'hf, r, e);
      chk(e, xsel(a) == 8'h00);
      acc(1'b0, 2'h2, a, 32'h0, 4'hf, r, e);
      if (xsel(a) != 8'h00) chk(r, v);
    end
    a0 = 32'h4200_0100;
    ref_mem[a0] = $urandom;
    acc(1'b1, 2'h2, a0, ref_mem[a0], 4'h0, r, e);
    for (int j = 0; j < 6; j++) begin
      m = (j < 4) ? 4'h1 << j : 4'h3 << (2 * (j - 4));
      v = $urandom;
      for (int l = 0; l < 4; l++) begin
        if (m[l]) ref_mem[a0][31-8*l -: 8] = v[31-8*l -: 8];
      end
      acc(1'b1, (j < 4) ? 2'h0 : 2'h1, a0 + ((j < 4) ? j : 2 * (j - 4)), v, ~m, r, e);
    end
    acc(1'b0, 2'h2, a0, 32'h0, 4'hf, r, e);
    chk(r, ref_mem[a0]);
    @(posedge i_core_clk);
    {i_req, i_cached, i_addr} <= {2'b11, 32'h0000_0040};
    repeat (8) @(posedge i_core_clk);
    chk({o_ack, sel, o_addr}, {9'h000, a0[27:0]});
    {i_req, i_cached} <= 2'b00;
    apb(1'b1, `REG_IRQ_CLR, 32'h3, r);
    apb(1'b1, `REG_IRQ_EN, 32'h2, r);
    i_fault <= 1'b1;
    acc(1'b0, 2'h2, a0, 32'h0, 4'hf, r, e);
    chk({e, r}, {1'b1, ref_mem[a0]});
    i_fault <= 1'b0;
    apb(1'b0, `REG_IRQ_STAT, 32'h0, r);
    chk({o_irq, r[1:0]}, 3'h7);
    apb(1'b1, `REG_IRQ_CLR, 32'h2, r);
    apb(1'b0, `REG_IRQ_STAT, 32'h0, r);
    chk({o_irq, r[1:0]}, 3'h1);
    apb(1'b1, `REG_CFG, 32'h0000_8007, r);
    tcb7 = 1'b1;
    apb(1'b1, `REG_GPIO_DIR, 32'h0000_ffff, r);
    v = $urandom;
    apb(1'b1, `REG_GPIO_OUT, v, r);
    repeat (2) @(posedge i_core_clk);
    chk({o_data_oe_n[15:0], o_data_out[15:0]}, {16'h0000, v[15:0]});
    v = $urandom;
    acc(1'b1, 2'h0, 32'h4100_0201, v, 4'he, r, e);
    acc(1'b0, 2'h0, 32'h4100_0201, 32'h0, 4'hf, r, e);
    chk(r[7:0], v[23:16]);
    end_of_test;
  end
endmodule

/* core/ext_mem_pins.v */
`timescale 1ns/1ps
`include "ext_mem_map.vh"
module ext_mem_pins (
  input wire i_core_clk, // 100 MHz core clock
  input wire i_arst_n, // async reset, active low
  // apb slave
  input wire i_psel, // apb select
  input wire i_penable, // apb access phase
  input wire i_pwrite, // apb direction
  input wire [7:0] i_paddr, // apb byte address
  input wire [31:0] i_pwdata, // apb write data
  output reg [31:0] o_prdata, // apb read data
  output reg o_pready, // apb ready
  output reg o_pslverr, // apb error
  output reg o_irq, // level interrupt
  // core request side
  input wire i_req, // access request
  input wire i_cached, // request served by cache
  input wire i_write, // store when high
  input wire [1:0] i_size, // byte/half/word
  input wire [31:0] i_addr, // internal address
  input wire [31:0] i_wdata, // store data, lane aligned
  output reg o_ack, // one-cycle completion
  output reg o_err, // memory error with ack
  output reg [31:0] o_rdata, // read data with ack
  // memory pins
  output reg [27:0] o_addr, // address bus
  input wire [31:0] i_data_in, // data bus level
  output reg [31:0] o_data_out, // data bus drive value
  output reg [31:0] o_data_oe_n, // data bus enable, low drives
  output reg [7:0] o_cb_out, // check bit drive value
  output reg o_cb_oe_n, // check bit enable, low drives
  output reg o_oe_n, // read output enable
  output reg o_read, // read strobe
  output reg o_write_n, // write strobe
  output reg [3:0] o_byte_write_strobe_n, // byte write enables
  output reg [1:0] o_boot_rom_select_n, // rom selects
  output reg [4:0] o_static_ram_bank_select_n, // ram selects
  output reg [4:0] o_static_ram_bank_output_enable_n, // ram oe
  output reg o_io_area_select_n, // io select
  input wire i_bus_ready_n, // ready from memory
  input wire i_bus_exception_n // exception from memory
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ACC = 3'b010;
  localparam [2:0] ST_END = 3'b100;

  // ================================================================
  // helper functions

  // byte strobes: lane 0 is bits 31:24
  function [3:0] byte_strobes;
    input [1:0] size;
    input [1:0] lo;
    input narrow;
    begin
      if (narrow || size == `SIZE_BYTE) begin
        byte_strobes = ~(4'h1 << (narrow ? 2'h0 : lo));
      end else if (size == `SIZE_HALF) begin
        byte_strobes = lo[1] ? 4'h3 : 4'hc;
      end else begin
        byte_strobes = 4'h0;
      end
    end
  endfunction

  // seven parity groups over the data word
  function [6:0] check_bits;
    input [31:0] d;
    integer i;
    integer j;
    reg [5:0] idx;
    begin
      check_bits = 7'h00;
      for (j = 0; j < 32; j = j + 1) begin
        idx = j[5:0] + 6'h01;
        for (i = 0; i < 6; i = i + 1) begin
          if (idx[i]) begin
            check_bits[i] = check_bits[i] ^ d[j];
          end
        end
        check_bits[6] = check_bits[6] ^ d[j];
      end
    end
  endfunction

  // ================================================================
  // state declarations
  reg [2:0] rst_cnt_q;
  reg run_q;
  reg [2:0] st_q;
  reg [31:0] cfg_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_en_q;
  reg [15:0] gpio_out_q;
  reg [15:0] gpio_dir_q;
  reg last_err_q;
  reg [31:0] din_s1_q;
  reg [31:0] din_s2_q;
  reg [31:0] din_s3_q;
  reg [1:0] ctl_s1_q;
  reg [1:0] ctl_s2_q;
  reg [1:0] ctl_s3_q;
  reg narrow_q;

  // ================================================================
  // decode of the incoming request
  wire [3:0] area = i_addr[31:28];
  wire hit_rom = (area == `AREA_ROM_LO) || (area == `AREA_ROM_HI);
  wire hit_io = (area == `AREA_IO_A) || (area == `AREA_IO_B);
  wire hit_ram_area = i_addr[`RAM_AREA_BIT];
  wire [2:0] bank = i_addr[`RAM_BANK_LSB+2:`RAM_BANK_LSB];
  wire hit_ram = hit_ram_area && (bank < `RAM_BANKS);
  wire mapped = hit_rom || hit_io || hit_ram;
  wire narrow = hit_rom ? cfg_q[`CFG_ROM8] :
                hit_io ? cfg_q[`CFG_IO8] : cfg_q[`CFG_RAM8];
  wire gpio_mode = cfg_q[`CFG_ROM8] && cfg_q[`CFG_RAM8] &&
                   cfg_q[`CFG_IO8] && !cfg_q[`CFG_SDRAM_EN];
  wire take = run_q && st_q[0] && i_req && !i_cached;

  // a level counts once stages two and three agree
  wire rdy_ok = !ctl_s2_q[0] && !ctl_s3_q[0];
  wire exc_ok = !ctl_s2_q[1] && !ctl_s3_q[1];
  // released only once both late stages read high, so one stray sample cannot free the bus
  wire rdy_idle = ctl_s2_q[0] && ctl_s3_q[0];

  // narrow byte moved to the top lane
  wire [1:0] lo = i_addr[1:0];
  wire [7:0] nbyte = i_wdata[8'd31 - {3'h0, lo, 3'h0} -: 8];

  // ================================================================
  // reset release counter: nothing starts before the fifth edge
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_cnt_q <= 3'h0;
      run_q <= 1'b0;
    end else begin
      if (rst_cnt_q != `RST_EDGES) begin
        rst_cnt_q <= rst_cnt_q + 3'h1;
      end
      run_q <= (rst_cnt_q == `RST_EDGES);
    end
  end

  // ================================================================
  // pin synchronisers, three stages each
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      din_s1_q <= 32'h0000_0000;
      din_s2_q <= 32'h0000_0000;
      din_s3_q <= 32'h0000_0000;
      ctl_s1_q <= 2'h3;
      ctl_s2_q <= 2'h3;
      ctl_s3_q <= 2'h3;
    end else begin
      din_s1_q <= i_data_in;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
      ctl_s1_q <= {i_bus_exception_n, i_bus_ready_n};
      ctl_s2_q <= ctl_s1_q;
      ctl_s3_q <= ctl_s2_q;
    end
  end

  // ================================================================
  // access sequencer and pin drivers
  // reset forces every strobe idle and the bus released
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= ST_IDLE;
      o_addr <= 28'h000_0000;
      o_data_out <= 32'h0000_0000;
      o_data_oe_n <= 32'hffff_ffff;
      o_cb_out <= 8'h00;
      o_cb_oe_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_read <= 1'b0;
      o_write_n <= 1'b1;
      o_byte_write_strobe_n <= 4'hf;
      o_boot_rom_select_n <= 2'h3;
      o_static_ram_bank_select_n <= 5'h1f;
      o_static_ram_bank_output_enable_n <= 5'h1f;
      o_io_area_select_n <= 1'b1;
      o_ack <= 1'b0;
      o_err <= 1'b0;
      o_rdata <= 32'h0000_0000;
      narrow_q <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // the address only moves on an external access
          if (take && !mapped) begin
            o_ack <= 1'b1;
            o_err <= 1'b1;
            // park one cycle so a request still held in the ack cycle is not taken twice
            st_q <= ST_END;
          end else if (take) begin
            st_q <= ST_ACC;
            narrow_q <= narrow;
            o_addr <= i_addr[27:0];
            o_err <= 1'b0;
            // exactly one select for the decoded area
            o_boot_rom_select_n <= hit_rom ? {!i_addr[28], i_addr[28]} : 2'h3;
            o_io_area_select_n <= !hit_io;
            if (hit_ram) begin
              o_static_ram_bank_select_n <= ~(5'h01 << bank);
              if (!i_write) begin
                o_static_ram_bank_output_enable_n <= ~(5'h01 << bank);
              end
            end
            if (i_write) begin
              o_write_n <= 1'b0;
              o_byte_write_strobe_n <= byte_strobes(i_size, lo, narrow);
              o_cb_out <= {cfg_q[`CFG_TCB_LSB+7], check_bits(i_wdata)};
              o_cb_oe_n <= 1'b0;
              if (narrow) begin
                o_data_out[31:24] <= nbyte;
                o_data_oe_n[31:24] <= 8'h00;
              end else begin
                o_data_out <= i_wdata;
                o_data_oe_n <= 32'h0000_0000;
              end
            end else begin
              o_oe_n <= 1'b0;
              o_read <= 1'b1;
            end
          end
        end
        ST_ACC: begin
          // ready low ends the access, high stretches it
          if (rdy_ok) begin
            st_q <= ST_END;
            o_ack <= 1'b1;
            o_err <= exc_ok;
            o_rdata <= narrow_q ? {24'h000000, din_s3_q[31:24]} : din_s3_q;
            o_oe_n <= 1'b1;
            o_read <= 1'b0;
            o_write_n <= 1'b1;
            o_byte_write_strobe_n <= 4'hf;
            o_boot_rom_select_n <= 2'h3;
            o_static_ram_bank_select_n <= 5'h1f;
            o_static_ram_bank_output_enable_n <= 5'h1f;
            o_io_area_select_n <= 1'b1;
            o_cb_oe_n <= 1'b1;
            o_data_oe_n[31:16] <= 16'hffff;
            if (!gpio_mode) begin
              o_data_oe_n[15:0] <= 16'hffff;
            end
          end
        end
        ST_END: begin
          // idle until stages two and three read ready high, so the old ready cannot end the next access
          if (rdy_idle) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
      // low half of the data bus belongs to gpio in this mode
      if (gpio_mode && !(st_q[1] && !narrow_q && !o_write_n)) begin
        o_data_out[15:0] <= gpio_out_q;
        o_data_oe_n[15:0] <= ~gpio_dir_q;
      end else if (st_q[0] && !take) begin
        o_data_oe_n[15:0] <= 16'hffff;
      end
    end
  end

  // ================================================================
  // apb slave: one wait state, data and ready from flops
  wire apb_acc = i_psel && i_penable;
  wire apb_wr = apb_acc && o_pready && i_pwrite;
  wire apb_map = (i_paddr[1:0] == 2'h0) && (i_paddr <= `REG_GPIO_IN);

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      `REG_CFG: rd_mux = cfg_q;
      `REG_STAT: rd_mux = {29'h0, last_err_q, gpio_mode, !st_q[0]};
      `REG_IRQ_STAT: rd_mux = {30'h0, irq_stat_q};
      `REG_IRQ_EN: rd_mux = {30'h0, irq_en_q};
      `REG_GPIO_OUT: rd_mux = {16'h0000, gpio_out_q};
      `REG_GPIO_DIR: rd_mux = {16'h0000, gpio_dir_q};
      `REG_GPIO_IN: rd_mux = {16'h0000, din_s3_q[15:0]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus handshake and register writes
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      cfg_q <= `CFG_RESET;
      irq_en_q <= 2'h0;
      gpio_out_q <= 16'h0000;
      gpio_dir_q <= 16'h0000;
    end else begin
      o_pready <= apb_acc && !o_pready;
      o_pslverr <= apb_acc && !o_pready && !apb_map;
      o_prdata <= (apb_acc && !o_pready && !i_pwrite) ? rd_mux : 32'h0000_0000;
      if (apb_wr) begin
        case (i_paddr)
          `REG_CFG: cfg_q <= i_pwdata;
          `REG_IRQ_EN: irq_en_q <= i_pwdata[1:0];
          `REG_GPIO_OUT: gpio_out_q <= i_pwdata[15:0];
          `REG_GPIO_DIR: gpio_dir_q <= i_pwdata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ================================================================
  // sticky events: a new event wins over a clear in the same cycle
  wire [1:0] ev = {o_ack && o_err, o_ack};
  wire [1:0] clr = (apb_wr && i_paddr == `REG_IRQ_CLR) ? i_pwdata[1:0] : 2'h0;
  wire [1:0] irq_stat_d = (irq_stat_q & ~clr) | ev;

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_q <= 2'h0;
      last_err_q <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (o_ack) begin
        last_err_q <= o_err;
      end
      o_irq <= |(irq_stat_d & irq_en_q);
    end
  end

endmodule

/* include/ext_mem_map.vh */
// Function
// - reset stops block; resume after fifth edge (run_q only rises on the sixth)
// - sample bus exception with read data
// - drive low 28 address bits only
// - cached access leaves address outputs unchanged
// - drive data bus only on stores
// - 8-bit areas use top byte lane
// - all 8-bit, no sdram: D[15:0] gpio
// - check bits driven on writes only
// - eighth check bit follows test field bit
// - reads assert output enable and read strobe
// - writes assert the write strobe
// - byte write enables from size, width
// - ready low ends access, high extends
// - rom select by lower/upper half
// - five ram selects with paired enables
// - io area gets its own select
`ifndef EXT_MEM_MAP_VH
`define EXT_MEM_MAP_VH
// ================================================================
// register byte offsets
`define REG_CFG 8'h00
`define REG_STAT 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_CLR 8'h0c
`define REG_IRQ_EN 8'h10
`define REG_GPIO_OUT 8'h14
`define REG_GPIO_DIR 8'h18
`define REG_GPIO_IN 8'h1c
// ================================================================
// config fields
`define CFG_ROM8 0
`define CFG_RAM8 1
`define CFG_IO8 2
`define CFG_SDRAM_EN 3
`define CFG_TCB_LSB 8
`define CFG_RESET 32'h0000_0000
// interrupt bits
`define IRQ_DONE 0
`define IRQ_MEMERR 1
// ================================================================
// address map: areas from the top nibble and bit 30, ram banks from bits 26:24
`define AREA_ROM_LO 4'h0
`define AREA_ROM_HI 4'h1
`define AREA_IO_A 4'h2
`define AREA_IO_B 4'h3
`define AREA_RAM_LSB 28
`define RAM_AREA_BIT 30
`define RAM_BANK_LSB 24
`define RAM_BANKS 5
// transfer sizes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
// ================================================================
// release delay after reset, in rising edges
`define RST_EDGES 3'h5
`endif
